// ---- rtl/mem_window_pkg.sv ----
// constants and carrier types for the bridge memory window registers
package mem_window_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_MEM_BOUNDS    = 8'h20;
  localparam logic [7:0] OFS_PF_BOUNDS     = 8'h24;
  localparam logic [7:0] OFS_PF_FLOOR_UP   = 8'h28;
  localparam logic [7:0] OFS_PF_CEIL_UP    = 8'h2C;
  // field positions
  localparam int unsigned CEIL_LSB  = 20;
  localparam int unsigned FLOOR_LSB = 4;
  localparam int unsigned FIELD_W   = 12;
  localparam logic [3:0]  ADDR_CAP_64 = 4'h1;
  localparam logic [31:0] MEM_BOUNDS_RST  = 32'h0000_0000;
  localparam logic [31:0] PF_BOUNDS_RST   = 32'h0001_0001;
  localparam logic [31:0] UPPER_WORD_RST  = 32'h0000_0000;
  localparam logic [19:0] LOW_ONES  = 20'hFFFFF;
  localparam logic [19:0] LOW_ZERO  = 20'h00000;
  localparam logic [11:0] FIELD_RST = 12'h000;

  typedef struct packed {
    logic [11:0] ceil_field;
    logic [11:0] floor_field;
  } window_fields_s;

  typedef struct packed {
    logic        hit;
    logic [63:0] lo;
    logic [63:0] hi;
  } window_view_s;
endpackage

// ---- rtl/bridge_memory_window_regs.sv ----
// memory and prefetchable window registers with address range decode
// Contract
// - memory ceiling field bits 31:20, low ones
// - memory floor field bits 15:4, low zeros
// - memory window decides forwarded transactions
// - prefetch ceiling field bits 31:20 writable
// - prefetch floor field bits 15:4 writable
// - capability nibbles read one, writes ignored
// - prefetch floor upper word gives 63:32
// - prefetch ceiling upper word gives 63:32
// - reset values zero, prefetch bounds 0x00010001
//
// Our own choice: the Wishbone interface to the registers.
module bridge_memory_window_regs (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [mem_window_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [63:0]                  txn_addr_i,
  output logic                              mem_fwd_o,
  output logic                              pf_fwd_o,
  output logic      [63:0]                  mem_lo_o,
  output logic      [63:0]                  mem_hi_o,
  output logic      [63:0]                  pf_lo_o,
  output logic      [63:0]                  pf_hi_o
);
  import mem_window_pkg::*;

  window_fields_s mem_reg, mem_next;
  window_fields_s pf_reg, pf_next;
  logic [31:0]    pf_floor_up_reg, pf_floor_up_next;
  logic [31:0]    pf_ceil_up_reg, pf_ceil_up_next;
  logic           ack_reg, ack_next;
  logic [31:0]    rdata_reg, rdata_next;
  window_view_s   mem_view, pf_view;
  logic           req;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // packs fields into a bounds word with a fixed low nibble pair
  function automatic logic [31:0] pack_bounds(input window_fields_s f, input logic [3:0] cap);
    return {f.ceil_field, cap, f.floor_field, cap};
  endfunction

  // one answer per request; ack drops the cycle after it was given
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;

  // register file next state
  always_comb begin
    logic [31:0] w;
    w                = 32'h0000_0000;
    mem_next         = mem_reg;
    pf_next          = pf_reg;
    pf_floor_up_next = pf_floor_up_reg;
    pf_ceil_up_next  = pf_ceil_up_reg;
    ack_next         = req;
    rdata_next       = rdata_reg;
    if (req) begin
      case (wb_adr_i)
        OFS_MEM_BOUNDS:  rdata_next = pack_bounds(mem_reg, 4'h0);
        OFS_PF_BOUNDS:   rdata_next = pack_bounds(pf_reg, ADDR_CAP_64);
        OFS_PF_FLOOR_UP: rdata_next = pf_floor_up_reg;
        OFS_PF_CEIL_UP:  rdata_next = pf_ceil_up_reg;
        default:         rdata_next = 32'h0000_0000; // unmapped reads zero, writes dropped
      endcase
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        OFS_MEM_BOUNDS: begin
          w = merge(pack_bounds(mem_reg, 4'h0), wb_dat_i, wb_sel_i);
          mem_next.ceil_field  = w[CEIL_LSB +: FIELD_W];
          mem_next.floor_field = w[FLOOR_LSB +: FIELD_W];
        end
        OFS_PF_BOUNDS: begin
          // capability nibbles never stored, so writes there vanish
          w = merge(pack_bounds(pf_reg, ADDR_CAP_64), wb_dat_i, wb_sel_i);
          pf_next.ceil_field  = w[CEIL_LSB +: FIELD_W];
          pf_next.floor_field = w[FLOOR_LSB +: FIELD_W];
        end
        OFS_PF_FLOOR_UP: pf_floor_up_next = merge(pf_floor_up_reg, wb_dat_i, wb_sel_i);
        OFS_PF_CEIL_UP:  pf_ceil_up_next  = merge(pf_ceil_up_reg, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_reg         <= '{FIELD_RST, FIELD_RST};
      pf_reg          <= '{FIELD_RST, FIELD_RST};
      pf_floor_up_reg <= UPPER_WORD_RST;
      pf_ceil_up_reg  <= UPPER_WORD_RST;
      ack_reg         <= 1'b0;
      rdata_reg       <= 32'h0000_0000;
    end else begin
      mem_reg         <= mem_next;
      pf_reg          <= pf_next;
      pf_floor_up_reg <= pf_floor_up_next;
      pf_ceil_up_reg  <= pf_ceil_up_next;
      ack_reg         <= ack_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // expanded bounds and combinational hit decode
  always_comb begin
    mem_view.lo  = {32'h0000_0000, mem_reg.floor_field, LOW_ZERO};
    mem_view.hi  = {32'h0000_0000, mem_reg.ceil_field, LOW_ONES};
    pf_view.lo   = {pf_floor_up_reg, pf_reg.floor_field, LOW_ZERO};
    pf_view.hi   = {pf_ceil_up_reg, pf_reg.ceil_field, LOW_ONES};
    // memory window is 32-bit only: upper address bits must be zero
    mem_view.hit = (txn_addr_i[63:32] == 32'h0000_0000) &&
                   (txn_addr_i >= mem_view.lo) && (txn_addr_i <= mem_view.hi);
    pf_view.hit  = (txn_addr_i >= pf_view.lo) && (txn_addr_i <= pf_view.hi);
  end

  assign mem_fwd_o = mem_view.hit;
  assign pf_fwd_o  = pf_view.hit;
  assign mem_lo_o  = mem_view.lo;
  assign mem_hi_o  = mem_view.hi;
  assign pf_lo_o   = pf_view.lo;
  assign pf_hi_o   = pf_view.hi;

  // checks
  AST_ACK_ONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
  AST_ACK_LAT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack not after one cycle");
  AST_CAP_READ: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_PF_BOUNDS) |=>
    (wb_dat_o[19:16] == 4'h1 && wb_dat_o[3:0] == 4'h1)) else $error("capability not one");
  AST_RSV_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_MEM_BOUNDS) |=>
    (wb_dat_o[19:16] == 4'h0 && wb_dat_o[3:0] == 4'h0)) else $error("reserved bits nonzero");
  AST_MEM_CEIL_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_MEM_BOUNDS && wb_sel_i == 4'hF) |=>
    (mem_hi_o[31:0] == {$past(wb_dat_i[31:20]), 20'hFFFFF})) else $error("mem ceiling wrong");
  AST_MEM_FLOOR_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_MEM_BOUNDS && wb_sel_i == 4'hF) |=>
    (mem_lo_o[31:0] == {$past(wb_dat_i[15:4]), 20'h00000})) else $error("mem floor wrong");
  AST_PF_CEIL_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_PF_BOUNDS && wb_sel_i == 4'hF) |=>
    (pf_hi_o[31:20] == $past(wb_dat_i[31:20]))) else $error("pf ceiling wrong");
  AST_PF_FLOOR_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_PF_BOUNDS && wb_sel_i == 4'hF) |=>
    (pf_lo_o[31:0] == {$past(wb_dat_i[15:4]), 20'h00000})) else $error("pf floor wrong");
  AST_PF_FLOOR_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_PF_FLOOR_UP && wb_sel_i == 4'hF) |=>
    (pf_lo_o[63:32] == $past(wb_dat_i))) else $error("pf floor upper wrong");
  AST_PF_CEIL_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == OFS_PF_CEIL_UP && wb_sel_i == 4'hF) |=>
    (pf_hi_o[63:32] == $past(wb_dat_i))) else $error("pf ceiling upper wrong");
  AST_PF_HIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pf_fwd_o == (txn_addr_i >= pf_lo_o && txn_addr_i <= pf_hi_o)) else $error("pf hit wrong");
  AST_MEM_HIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_fwd_o |-> (txn_addr_i >= mem_lo_o && txn_addr_i <= mem_hi_o)) else $error("mem hit wrong");

  // bounds seen right after reset leaves
  AST_RST_BOUNDS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (mem_lo_o == 64'h0000_0000_0000_0000 &&
                      mem_hi_o == 64'h0000_0000_000F_FFFF &&
                      pf_lo_o == 64'h0000_0000_0000_0000 &&
                      pf_hi_o == 64'h0000_0000_000F_FFFF)) else $error("reset bounds wrong");

  // bus side idle right after reset
  AST_RST_BUS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (!wb_ack_o && wb_dat_o == 32'h0000_0000)) else $error("reset bus wrong");

  // an answer only comes the cycle after a taken request
  AST_ACK_NEEDS_REQ: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(req)) else $error("ack without request");

  // no request, no answer next cycle
  AST_NO_ACK_IDLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack while idle");

  // read data stands until the next taken request
  AST_DAT_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !req |=> $stable(wb_dat_o)) else $error("read data moved");

  // low twenty bits of the memory floor are zero, upper word zero
  AST_MEM_LO_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_lo_o[19:0] == 20'h00000 && mem_lo_o[63:32] == 32'h0000_0000) else $error("mem lo low");

  // low twenty bits of the memory ceiling are ones, upper word zero
  AST_MEM_HI_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_hi_o[19:0] == 20'hFFFFF && mem_hi_o[63:32] == 32'h0000_0000) else $error("mem hi low");

  // prefetch floor low bits are zero
  AST_PF_LO_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pf_lo_o[19:0] == 20'h00000) else $error("pf lo low bits");

  // prefetch ceiling low bits are ones
  AST_PF_HI_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pf_hi_o[19:0] == 20'hFFFFF) else $error("pf hi low bits");

  // memory fields move only on a write to their word
  AST_MEM_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == OFS_MEM_BOUNDS) |=>
    ($stable(mem_hi_o[31:20]) && $stable(mem_lo_o[31:20]))) else $error("mem field moved");

  // prefetch fields move only on a write to their word
  AST_PF_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == OFS_PF_BOUNDS) |=>
    ($stable(pf_hi_o[31:20]) && $stable(pf_lo_o[31:20]))) else $error("pf field moved");

  // floor upper word moves only on its own write
  AST_PF_FLOOR_UP_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == OFS_PF_FLOOR_UP) |=>
    $stable(pf_lo_o[63:32])) else $error("pf floor upper moved");

  // ceiling upper word moves only on its own write
  AST_PF_CEIL_UP_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == OFS_PF_CEIL_UP) |=>
    $stable(pf_hi_o[63:32])) else $error("pf ceiling upper moved");

  // memory window never claims a 64-bit address
  AST_MEM_FWD_WIDE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    txn_addr_i[63:32] != 32'h0000_0000 |-> !mem_fwd_o) else $error("mem hit above 4G");

  // memory hit is exactly the 32-bit range test
  AST_MEM_FWD_EXACT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_fwd_o == (txn_addr_i[63:32] == 32'h0000_0000 && txn_addr_i >= mem_lo_o &&
                  txn_addr_i <= mem_hi_o)) else $error("mem hit not exact");

  // memory word read back matches the expanded bounds
  AST_READ_MEM: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_MEM_BOUNDS) |=>
    (wb_dat_o[31:20] == mem_hi_o[31:20] && wb_dat_o[15:4] == mem_lo_o[31:20]))
    else $error("mem read mismatch");

  // prefetch word read back matches the expanded bounds
  AST_READ_PF: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_PF_BOUNDS) |=>
    (wb_dat_o[31:20] == pf_hi_o[31:20] && wb_dat_o[15:4] == pf_lo_o[31:20]))
    else $error("pf read mismatch");

  // floor upper word read back
  AST_READ_FLOOR_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_PF_FLOOR_UP) |=>
    (wb_dat_o == pf_lo_o[63:32])) else $error("floor upper read mismatch");

  // ceiling upper word read back
  AST_READ_CEIL_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == OFS_PF_CEIL_UP) |=>
    (wb_dat_o == pf_hi_o[63:32])) else $error("ceiling upper read mismatch");

  // holes in the map read zero
  AST_UNMAPPED_READ: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i != OFS_MEM_BOUNDS && wb_adr_i != OFS_PF_BOUNDS &&
     wb_adr_i != OFS_PF_FLOOR_UP && wb_adr_i != OFS_PF_CEIL_UP) |=>
    (wb_dat_o == 32'h0000_0000)) else $error("unmapped read nonzero");

  // a prefetch hit lies at or above the floor
  AST_PF_FWD_FLOOR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pf_fwd_o |-> txn_addr_i >= pf_lo_o) else $error("pf hit below floor");

  COV_MEM_WRITE: cover property (@(posedge core_clk_i) disable iff (rst_i)
    req && wb_we_i && wb_adr_i == OFS_MEM_BOUNDS);
  COV_PF_READ: cover property (@(posedge core_clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == OFS_PF_BOUNDS);
  COV_MEM_HIT: cover property (@(posedge core_clk_i) disable iff (rst_i) mem_fwd_o);
  COV_PF_HIT: cover property (@(posedge core_clk_i) disable iff (rst_i)
    pf_fwd_o && txn_addr_i[63:32] != 32'h0000_0000);
  COV_UPPER_WRITE: cover property (@(posedge core_clk_i) disable iff (rst_i)
    req && wb_we_i && wb_adr_i == OFS_PF_CEIL_UP);
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the bridge memory window registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_window_pkg::*;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [63:0] txn  = 64'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        mem_fwd;
  logic        pf_fwd;
  logic [63:0] mem_lo;
  logic [63:0] mem_hi;
  logic [63:0] pf_lo;
  logic [63:0] pf_hi;
  int          mismatches  = 0;
  int          check_count = 0;

  bridge_memory_window_regs i_bridge_memory_window_regs (.core_clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .txn_addr_i(txn),
    .mem_fwd_o(mem_fwd), .pf_fwd_o(pf_fwd), .mem_lo_o(mem_lo), .mem_hi_o(mem_hi),
    .pf_lo_o(pf_lo), .pf_hi_o(pf_hi));

  // 200 MHz core clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic cycle: request held until the rising edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      $display("Error wishbone ack expected 1 seen none");
      wrap_up;
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, 4'hF, d, q);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 4'hF, 32'h0, q);
    chk(what, {32'h0, exp}, {32'h0, q});
  endtask

  // decode is combinational: settle the address, look at the next edge
  task automatic probe(input logic [63:0] a, input logic m, input logic p);
    @(posedge clk);
    txn <= a;
    @(posedge clk);
    chk("mem hit", {63'h0, m}, {63'h0, mem_fwd});
    chk("pf hit", {63'h0, p}, {63'h0, pf_fwd});
  endtask

  task automatic t_reset;
    rdchk("mem bounds", OFS_MEM_BOUNDS, 32'h0000_0000);
    rdchk("pf bounds", OFS_PF_BOUNDS, 32'h0001_0001);
    rdchk("pf floor up", OFS_PF_FLOOR_UP, 32'h0);
    rdchk("pf ceil up", OFS_PF_CEIL_UP, 32'h0);
    chk("mem hi", 64'h0000_0000_000F_FFFF, mem_hi);
  endtask

  task automatic t_mem;
    logic [31:0] q;
    wr(OFS_MEM_BOUNDS, 32'hFFFF_FFFF);
    rdchk("mem bounds", OFS_MEM_BOUNDS, 32'hFFF0_FFF0);
    chk("mem lo", 64'h0000_0000_FFF0_0000, mem_lo);
    chk("mem hi", 64'h0000_0000_FFFF_FFFF, mem_hi);
    bus(1'b1, OFS_MEM_BOUNDS, 4'h4, 32'h0, q); // only lane 2 cleared
    rdchk("mem lane", OFS_MEM_BOUNDS, 32'hFF00_FFF0);
    wr(OFS_MEM_BOUNDS, 32'h1FF0_1000);
    probe(64'h0, 1'b0, 1'b1);
    probe(64'h0FFF_FFFF, 1'b0, 1'b0);
    probe(64'h1000_0000, 1'b1, 1'b0);
    probe(64'h1FFF_FFFF, 1'b1, 1'b0);
    probe(64'h2000_0000, 1'b0, 1'b0);
    probe(64'h1_1000_0000, 1'b0, 1'b0);
  endtask

  task automatic t_pf;
    wr(OFS_PF_BOUNDS, 32'hFFFF_FFFF);
    rdchk("pf bounds", OFS_PF_BOUNDS, 32'hFFF1_FFF1);
    wr(OFS_PF_BOUNDS, 32'h0020_0010);
    rdchk("pf bounds", OFS_PF_BOUNDS, 32'h0021_0011);
    wr(OFS_PF_FLOOR_UP, 32'h0000_0001);
    wr(OFS_PF_CEIL_UP, 32'h0000_0002);
    rdchk("pf floor up", OFS_PF_FLOOR_UP, 32'h1);
    rdchk("pf ceil up", OFS_PF_CEIL_UP, 32'h2);
    chk("pf lo", 64'h0000_0001_0010_0000, pf_lo);
    chk("pf hi", 64'h0000_0002_002F_FFFF, pf_hi);
    probe(64'h1_000F_FFFF, 1'b0, 1'b0);
    probe(64'h1_0010_0000, 1'b0, 1'b1);
    probe(64'h2_002F_FFFF, 1'b0, 1'b1);
    probe(64'h2_0030_0000, 1'b0, 1'b0);
    wr(8'h30, 32'hFFFF_FFFF); // unmapped place swallows the write
    rdchk("unmapped", 8'h30, 32'h0);
  endtask

  // reset for 4 cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mem();
    t_pf();
    wrap_up();
  end
endmodule
